//--- logic/pef_params.svh
// Register offsets, bit positions and reset values of the peripheral event flag block.
`ifndef PEF_PARAMS_SVH
`define PEF_PARAMS_SVH

`define PEF_ADDR_W            8
`define PEF_DATA_W            8

`define PEF_ADDR_FLAGS        8'h0c
`define PEF_ADDR_STATUS       8'h0d
`define PEF_ADDR_MASK         8'h0e
`define PEF_ADDR_OVERRUN      8'h0f
`define PEF_ADDR_CAUSE        8'h10

`define PEF_BIT_OVERFLOW      0
`define PEF_BIT_PERIOD        1
`define PEF_BIT_CAPCMP        2
`define PEF_BIT_SERIAL        3
`define PEF_BIT_CONVERTER     6

`define PEF_IMPL_BITS         8'h4f
`define PEF_RESET_FLAGS       8'h00
`define PEF_RESET_MASK        8'h00
`define PEF_READ_UNMAPPED     8'h00

`define PEF_CAUSE_BYTE        0
`define PEF_CAUSE_START       1
`define PEF_CAUSE_STOP        2
`define PEF_CAUSE_RESTART     3
`define PEF_CAUSE_ACK         4
`define PEF_CAUSE_BUS_START   5
`define PEF_CAUSE_BUS_STOP    6
`define PEF_RESET_CAUSE       8'h00

`endif

//--- logic/pef_pkg.sv
// Types shared by the peripheral event flag block.
package pef_pkg;

    typedef enum logic [1:0] {
        PEF_SERIAL_OFF       = 2'h0,
        PEF_SERIAL_SPI       = 2'h1,
        PEF_SERIAL_I2C_SLAVE = 2'h3,
        PEF_SERIAL_I2C_MASTER = 2'h2
    } pef_serial_mode_type;

    typedef enum logic [1:0] {
        PEF_CCP_OFF     = 2'h0,
        PEF_CCP_CAPTURE = 2'h1,
        PEF_CCP_COMPARE = 2'h3,
        PEF_CCP_PWM     = 2'h2
    } pef_ccp_mode_type;

    typedef struct packed {
        logic conv_done;
        logic byte_done;
        logic start_done;
        logic stop_done;
        logic restart_done;
        logic ack_done;
        logic bus_start_seen;
        logic bus_stop_seen;
        logic capture_event;
        logic compare_match;
        logic period_match;
        logic timer_overflow;
    } pef_events_type;

    typedef struct packed {
        pef_serial_mode_type serial_mode;
        logic                serial_idle;
        logic                multi_master;
        pef_ccp_mode_type    ccp_mode;
    } pef_config_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pef_bus_req_type;

endpackage

//--- logic/pef_event_decode.sv
// Qualifies raw peripheral event pulses by mode and maps them onto flag positions.
`timescale 1ns/100ps
`default_nettype none
`include "pef_params.svh"

module pef_event_decode (
    input  wire pef_pkg::pef_events_type events_i,      // Raw one-cycle event pulses
    input  wire pef_pkg::pef_config_type config_i,      // Peripheral mode settings
    output logic [7:0]                   set_o,         // Per-flag set request
    output logic [7:0]                   cause_o        // Serial port cause vector
);
    import pef_pkg::*;

    logic is_i2c;
    logic is_serial_on;
    logic [7:0] cause;

    always_comb begin
        is_i2c       = (config_i.serial_mode == PEF_SERIAL_I2C_SLAVE) ||
                       (config_i.serial_mode == PEF_SERIAL_I2C_MASTER);
        is_serial_on = (config_i.serial_mode != PEF_SERIAL_OFF);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        cause                          = 8'h00;
        cause[`PEF_CAUSE_BYTE]         = is_serial_on && events_i.byte_done;            // R03
        cause[`PEF_CAUSE_START]        = is_i2c && events_i.start_done;                 // R04
        cause[`PEF_CAUSE_STOP]         = is_i2c && events_i.stop_done;                  // R04
        cause[`PEF_CAUSE_RESTART]      = is_i2c && events_i.restart_done;               // R04
        cause[`PEF_CAUSE_ACK]          = is_i2c && events_i.ack_done;                   // R04
        // Bus conditions only matter when another master may own the bus.
        cause[`PEF_CAUSE_BUS_START]    = is_i2c && config_i.multi_master &&
                                         config_i.serial_idle && events_i.bus_start_seen; // R05
        cause[`PEF_CAUSE_BUS_STOP]     = is_i2c && config_i.multi_master &&
                                         config_i.serial_idle && events_i.bus_stop_seen;  // R05
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        set_o                     = 8'h00;
        set_o[`PEF_BIT_CONVERTER] = events_i.conv_done;                                    // R02
        set_o[`PEF_BIT_SERIAL]    = |cause;                                                // R03
        // In PWM mode the capture/compare position is unused and never set.
        set_o[`PEF_BIT_CAPCMP]    = ((config_i.ccp_mode == PEF_CCP_CAPTURE) && events_i.capture_event) || // R07
                                    ((config_i.ccp_mode == PEF_CCP_COMPARE) && events_i.compare_match);   // R08
        set_o[`PEF_BIT_PERIOD]    = events_i.period_match;                                 // R09
        set_o[`PEF_BIT_OVERFLOW]  = events_i.timer_overflow;                               // R10
        cause_o                   = cause;
    end

endmodule
`default_nettype wire

//--- logic/pef_flags.sv
// Peripheral event flag register with sticky status, mask and interrupt output.
//
// Operation
// [R01] Positions 7, 5 and 4 read zero and hold no state.
// [R02] Position 6 sets when a conversion finishes; zero means none pending.
// [R03] Position 3 sets on every completed serial byte transfer, SPI or I2C.
// [R04] In I2C mode position 3 also sets when own start/stop/restart/ack completes.
// [R05] Multi-master I2C: bus start or stop seen while idle sets position 3.
// [R06] Software clears the serial flag before leaving its service routine.
// [R07] Capture mode: position 2 sets on capture, stays until software clears.
// [R08] Compare mode: position 2 sets on match; unused in PWM mode.
// [R09] Position 1 sets when second timer count equals its period.
// [R10] Position 0 sets when first timer count overflows.
// [R11] Flags set on events regardless of any enable bit.
// [R12] Flags reset to zero; hardware set beats a same-cycle software write.
`timescale 1ns/100ps
`default_nettype none
`include "pef_params.svh"

module pef_flags #(
    parameter logic [7:0] IMPL_BITS = `PEF_IMPL_BITS    // Positions that hold state
) (
    input  wire logic                     clock_i,      // System clock, 200 MHz
    input  wire logic                     rst_i,        // Asynchronous reset, active high
    input  wire pef_pkg::pef_bus_req_type bus_i,        // Register access request
    output logic [7:0]                    rdata_o,      // Read data, cycle after the read strobe
    input  wire pef_pkg::pef_events_type  events_i,     // Peripheral event pulses
    input  wire pef_pkg::pef_config_type  config_i,     // Peripheral mode settings
    output logic [7:0]                    flags_o,      // Flag register, registered one cycle late
    output logic                          irq_o         // Level interrupt
);
    import pef_pkg::*;

    logic [7:0] set_req;
    logic [7:0] cause_req;
    logic [7:0] flags;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] overrun;
    logic [7:0] cause;
    logic [7:0] next_rdata;
    logic       wr_flags;
    logic       wr_status;
    logic       wr_mask;
    logic       wr_overrun;

    ////////////////////////////////////////////////////////////////////////////
    pef_event_decode u_decode (
        .events_i (events_i),
        .config_i (config_i),
        .set_o    (set_req),
        .cause_o  (cause_req)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode. Strobes never overlap, so one write target per cycle.
    always_comb begin
        wr_flags   = bus_i.wr && (bus_i.addr == `PEF_ADDR_FLAGS);
        wr_status  = bus_i.wr && (bus_i.addr == `PEF_ADDR_STATUS);
        wr_mask    = bus_i.wr && (bus_i.addr == `PEF_ADDR_MASK);
        wr_overrun = bus_i.wr && (bus_i.addr == `PEF_ADDR_OVERRUN);
    end

    ////////////////////////////////////////////////////////////////////////////
    // One slice per flag position. Unused positions are constant zero, so a
    // write of ones there is dropped and never shows on a read.
    for (genvar i = 0; i < 8; i++) begin : g_bit
        if (IMPL_BITS[i]) begin : g_impl
            // The flag itself is plain read/write; software may also set it.
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    flags[i] <= 1'b0;                                                // R12
                end else if (set_req[i]) begin
                    flags[i] <= 1'b1;                                                // R11
                end else if (wr_flags) begin
                    flags[i] <= bus_i.wdata[i];                                      // R06
                end
            end

            // Sticky status, cleared by writing a one; set wins over clear.
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    status[i] <= 1'b0;
                end else if (set_req[i]) begin
                    status[i] <= 1'b1;                                               // R12
                end else if (wr_status && bus_i.wdata[i]) begin
                    status[i] <= 1'b0;
                end
            end

            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    mask[i] <= 1'(`PEF_RESET_MASK >> i);
                end else if (wr_mask) begin
                    mask[i] <= bus_i.wdata[i];
                end
            end

            // A second event on a flag that is still set cannot be told apart
            // from the first; this bit records that one was merged.
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    overrun[i] <= 1'b0;
                end else if (set_req[i] && flags[i]) begin
                    overrun[i] <= 1'b1;
                end else if (wr_overrun && bus_i.wdata[i]) begin
                    overrun[i] <= 1'b0;
                end
            end
        end else begin : g_unused
            assign flags[i]   = 1'b0;                                                // R01
            assign status[i]  = 1'b0;                                                // R01
            assign mask[i]    = 1'b0;
            assign overrun[i] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial cause record: the serial flag has many sources, so software can
    // see which ones fired since it last cleared this register. Writing a one
    // clears a cause bit; a fresh cause in the same cycle stays.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cause <= `PEF_RESET_CAUSE;
        end else if (bus_i.wr && (bus_i.addr == `PEF_ADDR_CAUSE)) begin
            cause <= (cause & ~bus_i.wdata) | cause_req;                             // R12
        end else begin
            cause <= cause | cause_req;                                              // R03
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux. Unmapped addresses answer zero.
    always_comb begin
        case (bus_i.addr)
            `PEF_ADDR_FLAGS:   next_rdata = flags & IMPL_BITS;                       // R01
            `PEF_ADDR_STATUS:  next_rdata = status;
            `PEF_ADDR_MASK:    next_rdata = mask;
            `PEF_ADDR_OVERRUN: next_rdata = overrun;
            `PEF_ADDR_CAUSE:   next_rdata = cause;
            default:           next_rdata = `PEF_READ_UNMAPPED;
        endcase
    end

    // Read data stand only in the cycle after the strobe and are zero otherwise.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            flags_o <= `PEF_RESET_FLAGS;
        end else begin
            flags_o <= flags;
        end
    end

    // Registered for a clean output; the interrupt lags status by one cycle.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status & mask);
        end
    end

endmodule
`default_nettype wire

//--- sim/pef_flags_props.sv
// Concurrent checks on the ports of the peripheral event flag block.
`timescale 1ns/100ps
`default_nettype none
`include "pef_params.svh"

module pef_flags_props #(
    parameter logic [7:0] IMPL_BITS = `PEF_IMPL_BITS    // Positions that hold state
) (
    input  wire logic                     clock_i,      // System clock
    input  wire logic                     rst_i,        // Asynchronous reset
    input  wire pef_pkg::pef_bus_req_type bus_i,        // Register access request
    input  wire logic [7:0]               rdata_o,      // Read data
    input  wire pef_pkg::pef_events_type  events_i,     // Event pulses
    input  wire pef_pkg::pef_config_type  config_i,     // Mode settings
    input  wire logic [7:0]               flags_o,      // Flag register copy
    input  wire logic                     irq_o         // Level interrupt
);
    import pef_pkg::*;
    logic i2c_on;
    assign i2c_on = config_i.serial_mode inside {PEF_SERIAL_I2C_SLAVE, PEF_SERIAL_I2C_MASTER};
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////
    sequence flags_read_s;
        bus_i.rd && bus_i.addr == `PEF_ADDR_FLAGS;
    endsequence
    sequence flags_write_s;
        bus_i.wr && bus_i.addr == `PEF_ADDR_FLAGS;
    endsequence
    // A set shows on flags_o two edges after the pulse, whatever writes follow it.
    unused_bits_zero_a: assert property (flags_o[7] == 1'b0 && flags_o[5:4] == 2'h0)
        else $error("unused flag positions not zero");
    unused_read_zero_a: assert property (flags_read_s |=> (rdata_o & 8'hb0) == 8'h00)
        else $error("unused positions read back nonzero");
    overflow_sets_a: assert property (events_i.timer_overflow |-> ##2 flags_o[`PEF_BIT_OVERFLOW])
        else $error("overflow flag not set");
    period_sets_a: assert property (events_i.period_match |-> ##2 flags_o[`PEF_BIT_PERIOD])
        else $error("period match flag not set");
    converter_sets_a: assert property (events_i.conv_done |-> ##2 flags_o[`PEF_BIT_CONVERTER])
        else $error("converter flag not set");
    capture_sets_a: assert property (events_i.capture_event && config_i.ccp_mode == PEF_CCP_CAPTURE
        |-> ##2 flags_o[`PEF_BIT_CAPCMP])
        else $error("capture flag not set");
    compare_sets_a: assert property (events_i.compare_match && config_i.ccp_mode == PEF_CCP_COMPARE
        |-> ##2 flags_o[`PEF_BIT_CAPCMP])
        else $error("compare flag not set");
    serial_byte_a: assert property (events_i.byte_done && config_i.serial_mode != PEF_SERIAL_OFF
        |-> ##2 flags_o[`PEF_BIT_SERIAL])
        else $error("serial flag not set on byte");
    serial_own_a: assert property (i2c_on && (events_i.start_done || events_i.stop_done
        || events_i.restart_done || events_i.ack_done) |-> ##2 flags_o[`PEF_BIT_SERIAL])
        else $error("serial flag not set on own condition");
    serial_bus_a: assert property (i2c_on && config_i.multi_master && config_i.serial_idle
        && (events_i.bus_start_seen || events_i.bus_stop_seen) |-> ##2 flags_o[`PEF_BIT_SERIAL])
        else $error("serial flag not set on bus condition");
    flags_sticky_a: assert property (|($past(flags_o) & ~flags_o) |-> $past(bus_i.wr, 2)
        && $past(bus_i.addr, 2) == `PEF_ADDR_FLAGS)
        else $error("flag cleared without a software write");
    cover property (flags_write_s ##0 events_i.timer_overflow);
endmodule

bind pef_flags pef_flags_props #(.IMPL_BITS(IMPL_BITS)) u_pef_flags_props (
    .clock_i  (clock_i),
    .rst_i    (rst_i),
    .bus_i    (bus_i),
    .rdata_o  (rdata_o),
    .events_i (events_i),
    .config_i (config_i),
    .flags_o  (flags_o),
    .irq_o    (irq_o)
);
`default_nettype wire

//--- sim/pef_event_model.sv
// Behavioural peripheral event sources that report completions to the flag block.
`timescale 1ns/100ps
`default_nettype none

module pef_event_model (
    input  wire logic                   clock_i,    // System clock
    input  wire logic                   rst_i,      // Asynchronous reset
    input  wire logic [11:0]            fire_i,     // Events to report at the next edge
    output var  pef_pkg::pef_events_type events_o   // One-cycle event pulses
);
    import pef_pkg::*;
    // Sources report a finished event as one pulse, so a held fire_i would look like many events.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            events_o <= '0;
        end else begin
            events_o <= fire_i;
        end
    end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the peripheral event flag block.
`timescale 1ns/100ps
`default_nettype none
`include "pef_params.svh"

module tb_top;
    import pef_pkg::*;
    logic            clock_i = 1'b0;
    logic            rst_i = 1'b1;
    pef_bus_req_type bus = '0;
    pef_config_type  cfg = '0;
    pef_events_type  events;
    logic [11:0]     fire = '0;
    logic [7:0]      rdata, flags, v;
    logic            irq;
    int              num_errors = 0;
    int              total_checks = 0;
    // Row: events [31:20], mode settings [13:8], expected flags [7:0].
    localparam logic [31:0] ROWS [18] = '{32'h0010_0001, 32'h0020_0002, 32'h8000_0040, 32'h0080_0104,
        32'h0040_0304, 32'h0080_0200, 32'h0040_0100, 32'h4000_1008, 32'h4000_0000, 32'h2000_2008,
        32'h1000_3008, 32'h0800_2008, 32'h0400_3008, 32'h2000_1000, 32'h0200_3C08, 32'h0100_2C08,
        32'h0200_3800, 32'h0100_2400};
    always #2.5 clock_i = ~clock_i;
    pef_event_model u_pef_event_model (.clock_i(clock_i), .rst_i(rst_i), .fire_i(fire), .events_o(events));
    pef_flags u_pef_flags (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
        .events_i(events), .config_i(cfg), .flags_o(flags), .irq_o(irq));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        total_checks++;
        if (seen !== expected) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock_i);
        bus.wr <= 1'b0;
        // One idle edge, so a following write never drives the strobe twice in one step.
        @(posedge clock_i);
    endtask
    // Read data stand in the cycle after the strobe, so they are taken at the edge closing it.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock_i);
        bus.rd <= 1'b0;
        @(posedge clock_i);
        d = rdata;
    endtask
    task automatic pulse(input logic [11:0] e);
        fire <= e;
        @(posedge clock_i);
        fire <= '0;
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clock_i);
        num_errors++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check(flags, 8'h00);
        rd_reg(`PEF_ADDR_FLAGS, v);
        check(v, 8'h00);
        foreach (ROWS[i]) begin
            cfg <= pef_config_type'(ROWS[i][13:8]);
            wr_reg(`PEF_ADDR_FLAGS, 8'h00);
            pulse(ROWS[i][31:20]);
            repeat (3) @(posedge clock_i);
            check(flags, ROWS[i][7:0]);
            rd_reg(`PEF_ADDR_FLAGS, v);
            check(v, ROWS[i][7:0]);
        end
        wr_reg(`PEF_ADDR_FLAGS, 8'hff);
        rd_reg(`PEF_ADDR_FLAGS, v);
        check(v, 8'h4f);
        wr_reg(8'h20, 8'hff);
        rd_reg(8'h20, v);
        check(v, 8'h00);
        wr_reg(`PEF_ADDR_FLAGS, 8'h00);
        wr_reg(`PEF_ADDR_STATUS, 8'hff);
        pulse(12'h001);
        wr_reg(`PEF_ADDR_FLAGS, 8'h00);
        repeat (2) @(posedge clock_i);
        check(flags, 8'h01);
        wr_reg(`PEF_ADDR_STATUS, 8'hff);
        wr_reg(`PEF_ADDR_MASK, 8'h01);
        pulse(12'h001);
        repeat (3) @(posedge clock_i);
        check({7'h00, irq}, 8'h01);
        wr_reg(`PEF_ADDR_STATUS, 8'h01);
        repeat (2) @(posedge clock_i);
        check({7'h00, irq}, 8'h00);
        wr_reg(`PEF_ADDR_MASK, 8'h00);
        pulse(12'h001);
        repeat (3) @(posedge clock_i);
        check({7'h00, irq}, 8'h00);
        rd_reg(`PEF_ADDR_STATUS, v);
        check(v, 8'h01);
        rd_reg(`PEF_ADDR_OVERRUN, v);
        check(v, 8'h01);
        wr_reg(`PEF_ADDR_OVERRUN, 8'h01);
        rd_reg(`PEF_ADDR_OVERRUN, v);
        check(v, 8'h00);
        rd_reg(`PEF_ADDR_CAUSE, v);
        check(v, 8'h7f);
        wr_reg(`PEF_ADDR_CAUSE, 8'h7f);
        rd_reg(`PEF_ADDR_CAUSE, v);
        check(v, 8'h00);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check(flags, 8'h00);
        rd_reg(`PEF_ADDR_STATUS, v);
        check(v, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
